// [inc/rcs_pkg.sv]
/*
  Constants and types shared by the reset-cause status block and its
  watchdog counter: status bit positions, reset values, service codes,
  timing counts and the sequencer state enumeration.
  Assumes a single 50 MHz bus clock and 8-bit register data.

  // Contract
  // - Status flags are read-only and a read never changes them.
  // - A debug-forced reset leaves every status flag cleared.
  // - With watchdog enabled, a status write other than 0x55/0xAA forces reset.
  // - Writing 0x55 then 0xAA clears the watchdog, flags stay unchanged.
  // - Power-on reset sets bit 7 and bit 1, clears all others.
  // - Enabled undervoltage reset sets bit 1, keeps bit 7, clears others.
  // - At reset entry each active source sets its bit, inactive ones clear.
  // - Low level on the external reset input sets bit 6.
  // - Watchdog timeout sets bit 5; blocked while watchdog disabled.
  // - Unimplemented, disallowed halt or debug-halt opcode resets, sets bit 4.
  // - Access to an unimplemented address resets and sets bit 3.
  // - Loss of the external clock resets and sets bit 2.
  // - Force-reset register ignores user writes, reads 0x00, needs debug write.
  // - Debug write of 1 to bit 0 of force register resets the MCU.
*/
package rcs_pkg;

  // Register data width
  localparam int unsigned RCS_DATA_W = 8;

  // Status bit positions
  localparam int unsigned RCS_BIT_POR  = 7;
  localparam int unsigned RCS_BIT_PIN  = 6;
  localparam int unsigned RCS_BIT_WDOG = 5;
  localparam int unsigned RCS_BIT_OPC  = 4;
  localparam int unsigned RCS_BIT_ADR  = 3;
  localparam int unsigned RCS_BIT_CLK  = 2;
  localparam int unsigned RCS_BIT_UV   = 1;
  localparam int unsigned RCS_BIT_ZERO = 0;

  // Status value left by a power-on reset
  localparam logic [RCS_DATA_W-1:0] RCS_POR_VALUE    = 8'h82;
  // Watchdog service codes
  localparam logic [RCS_DATA_W-1:0] RCS_SVC_FIRST    = 8'h55;
  localparam logic [RCS_DATA_W-1:0] RCS_SVC_SECOND   = 8'haa;
  // Fixed read value of the force-reset register
  localparam logic [RCS_DATA_W-1:0] RCS_FORCE_RDATA  = 8'h00;
  localparam int unsigned           RCS_FORCE_BIT    = 0;

  // Register select codes
  localparam logic RCS_SEL_STATUS = 1'b0;
  localparam logic RCS_SEL_FORCE  = 1'b1;

  // Reset pulse length in bus cycles
  localparam int unsigned             RCS_HOLD_W    = 5;
  localparam logic [RCS_HOLD_W-1:0]   RCS_HOLD_LAST = 5'h0f;
  localparam logic [RCS_HOLD_W-1:0]   RCS_HOLD_STEP = 5'h01;

  // Watchdog counter width and default timeout in bus cycles
  localparam int unsigned RCS_WDOG_W       = 18;
  localparam int unsigned RCS_WDOG_DEFAULT = 8192;

  // Sequencer states
  typedef enum logic {
    RCS_RUN,
    RCS_HOLD
  } rcs_state_t;

endpackage : rcs_pkg

// [logic/rcs_watchdog.sv]
/*
  Watchdog counter of the reset-cause block.
  Assumes enable and clear are synchronous to ref_clk_i; timeout_o is a
  one-cycle pulse when the count reaches the timeout.
*/
`timescale 1ns/1ps
module rcs_watchdog
  import rcs_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYCLES = RCS_WDOG_DEFAULT
) (
  // Clock and reset
  input  wire logic ref_clk_i,
  input  wire logic resetn_i,
  // Control
  input  wire logic enable_i,
  input  wire logic clear_i,
  // Event
  output logic      timeout_o
);

  typedef struct packed {
    logic [RCS_WDOG_W-1:0] count;
    logic                  timeout;
  } rcs_wdog_t;

  localparam logic [RCS_WDOG_W-1:0] LAST = RCS_WDOG_W'(TIMEOUT_CYCLES - 1);
  localparam logic [RCS_WDOG_W-1:0] STEP = 18'h00001;

  rcs_wdog_t cur;
  rcs_wdog_t next_cur;

  // Count is held at zero while disabled so no timeout can escape
  always_comb begin
    next_cur         = cur;
    next_cur.timeout = 1'b0;
    if (clear_i || !enable_i) begin
      next_cur.count = '0;
    end else if (cur.count == LAST) begin
      next_cur.count   = '0;
      next_cur.timeout = 1'b1;
    end else begin
      next_cur.count = cur.count + STEP;
    end
  end

  // State register
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign timeout_o = cur.timeout;

endmodule : rcs_watchdog

// [logic/rcs_reset_status.sv]
/*
  Reset-cause capture, watchdog service port and debug-forced reset.
  Holds the reset cause status register and the debug force-reset
  register, and drives the MCU reset request.
  Assumes resetn_i is the power-on reset of this block only; the MCU
  reset it drives does not reset this block, so the flags survive.
  Source inputs are synchronous to ref_clk_i; opcode and address
  faults are one-cycle strobes from the core.
*/
`timescale 1ns/1ps
module rcs_reset_status
  import rcs_pkg::*;
#(
  parameter int unsigned WDOG_TIMEOUT_CYCLES = RCS_WDOG_DEFAULT
) (
  // Clock and power-on reset
  input  wire logic                  ref_clk_i,
  input  wire logic                  resetn_i,

  // Register access port
  input  wire logic                  reg_sel_i,
  input  wire logic                  reg_wr_i,
  input  wire logic                  reg_rd_i,
  input  wire logic                  reg_bdm_i,
  input  wire logic [RCS_DATA_W-1:0] reg_wdata_i,
  output logic      [RCS_DATA_W-1:0] reg_rdata_o,

  // Pin and supply sources
  input  wire logic                  ext_reset_n_i,
  input  wire logic                  undervoltage_i,
  input  wire logic                  undervoltage_reset_enable_i,
  input  wire logic                  ext_clk_missing_i,

  // Core fault strobes and options
  input  wire logic                  opcode_unimpl_i,
  input  wire logic                  halt_instr_i,
  input  wire logic                  halt_mode_permit_i,
  input  wire logic                  debug_halt_instruction_i,
  input  wire logic                  background_mode_permit_i,
  input  wire logic                  bad_address_i,

  // Watchdog option
  input  wire logic                  watchdog_enable_i,

  // Reset request and status view
  output logic                       mcu_reset_o,
  output logic      [RCS_DATA_W-1:0] reset_cause_status_o
);

  // Whole state of the block
  typedef struct packed {
    rcs_state_t              state;
    logic [RCS_HOLD_W-1:0]   hold;
    logic [RCS_DATA_W-1:0]   status;
    logic                    armed;
    logic [RCS_DATA_W-1:0]   rdata;
  } rcs_main_t;

  // Power-on leaves the MCU held in reset with the power-on cause
  localparam rcs_main_t RESET_ST = '{
    state:  RCS_HOLD,
    hold:   RCS_HOLD_LAST,
    status: RCS_POR_VALUE,
    armed:  1'b0,
    rdata:  '0
  };

  rcs_main_t cur;
  rcs_main_t next_cur;

  // Decoded accesses and events
  logic running;
  logic wr_status;
  logic wr_force;
  logic svc_first;
  logic svc_second;
  logic bad_write;
  logic service_ok;
  logic wdog_timeout;
  logic wdog_clear;
  logic wdog_run;
  logic src_pin;
  logic src_wdog;
  logic src_opc;
  logic src_adr;
  logic src_clk;
  logic src_uv;
  logic force_req;
  logic any_src;
  logic [RCS_DATA_W-1:0] captured;

  // Register writes are only honoured while the core runs; reads are not gated
  assign running    = (cur.state == RCS_RUN);
  assign wr_status  = reg_wr_i && (reg_sel_i == RCS_SEL_STATUS) && running;
  assign wr_force   = reg_wr_i && (reg_sel_i == RCS_SEL_FORCE) && running;

  // Service code compare
  assign svc_first  = (reg_wdata_i == RCS_SVC_FIRST);
  assign svc_second = (reg_wdata_i == RCS_SVC_SECOND);

  // Any other value written while the watchdog is on is a fault
  assign bad_write  = wr_status && watchdog_enable_i
                      && !svc_first && !svc_second;

  // Second half of the sequence only counts after the first half
  assign service_ok = wr_status && watchdog_enable_i
                      && svc_second && cur.armed;

  // Counter is frozen at zero during the reset pulse
  assign wdog_run   = running && watchdog_enable_i;
  assign wdog_clear = service_ok || !running;

  // Watchdog counter
  rcs_watchdog #(
    .TIMEOUT_CYCLES (WDOG_TIMEOUT_CYCLES)
  ) u_watchdog (
    .ref_clk_i (ref_clk_i),
    .resetn_i  (resetn_i),
    .enable_i  (wdog_run),
    .clear_i   (wdog_clear),
    .timeout_o (wdog_timeout)
  );

  // Reset sources as seen in the current cycle
  assign src_pin  = !ext_reset_n_i;
  assign src_wdog = (wdog_timeout && watchdog_enable_i) || bad_write;
  assign src_opc  = opcode_unimpl_i
                    || (halt_instr_i && !halt_mode_permit_i)
                    || (debug_halt_instruction_i && !background_mode_permit_i);
  assign src_adr  = bad_address_i;
  assign src_clk  = ext_clk_missing_i;
  assign src_uv   = undervoltage_i && undervoltage_reset_enable_i;

  // Only a debug write may force a reset; user writes fall away
  assign force_req = wr_force && reg_bdm_i
                     && reg_wdata_i[RCS_FORCE_BIT];

  // Anything that starts a reset pulse
  assign any_src = src_pin || src_wdog || src_opc || src_adr
                   || src_clk || src_uv || force_req;

  // Status image taken at reset entry; the debug force has no bit
  always_comb begin
    captured               = '0;
    captured[RCS_BIT_POR]  = src_uv && cur.status[RCS_BIT_POR];
    captured[RCS_BIT_PIN]  = src_pin;
    captured[RCS_BIT_WDOG] = src_wdog;
    captured[RCS_BIT_OPC]  = src_opc;
    captured[RCS_BIT_ADR]  = src_adr;
    captured[RCS_BIT_CLK]  = src_clk;
    captured[RCS_BIT_UV]   = src_uv;
    captured[RCS_BIT_ZERO] = 1'b0;
  end

  // Next-state logic
  always_comb begin
    next_cur = cur;

    unique case (cur.state)
      // Normal operation: watch for sources and service writes
      RCS_RUN: begin
        if (any_src) begin
          next_cur.state  = RCS_HOLD;
          next_cur.hold   = RCS_HOLD_LAST;
          next_cur.status = captured;
          next_cur.armed  = 1'b0;
        end else if (wr_status && watchdog_enable_i) begin
          // Status flags are never written; only the arm bit moves
          next_cur.armed  = svc_first;
        end
      end

      // Reset pulse: sources are ignored until the pulse ends
      RCS_HOLD: begin
        next_cur.armed = 1'b0;
        if (cur.hold == '0) begin
          next_cur.state = RCS_RUN;
        end else begin
          next_cur.hold = cur.hold - RCS_HOLD_STEP;
        end
      end
    endcase

    // Read data; reading has no side effect on any flag
    if (reg_rd_i) begin
      if (reg_sel_i == RCS_SEL_STATUS) begin
        next_cur.rdata = cur.status;
      end else begin
        next_cur.rdata = RCS_FORCE_RDATA;
      end
    end
  end

  // State register
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cur <= RESET_ST;
    end else begin
      cur <= next_cur;
    end
  end

  // Outputs straight from the state register
  assign mcu_reset_o          = (cur.state == RCS_HOLD);
  assign reg_rdata_o          = cur.rdata;
  assign reset_cause_status_o = cur.status;

endmodule : rcs_reset_status

// [tb/rcs_props.sv]
/* Port checker of the reset-cause block.
   Bound to rcs_reset_status from the bench top; single clock domain. */
`timescale 1ns/1ps
module rcs_props (
  // Watched ports
  input wire logic       ref_clk_i,
  input wire logic       resetn_i,
  input wire logic       reg_sel_i,
  input wire logic       reg_wr_i,
  input wire logic       reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic       ext_reset_n_i,
  input wire logic       bad_address_i,
  input wire logic       watchdog_enable_i,
  input wire logic       mcu_reset_o,
  input wire logic [7:0] reg_rdata_o,
  input wire logic [7:0] reset_cause_status_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);
  // Sources taken in run show in the status one edge later
  a_pin_flag: assert property (!mcu_reset_o && !ext_reset_n_i |=> mcu_reset_o && reset_cause_status_o[6])
    else $error("pin flag missing");
  a_adr_flag: assert property (!mcu_reset_o && bad_address_i |=> mcu_reset_o && reset_cause_status_o[3])
    else $error("address flag missing");
  a_bad_write: assert property (!mcu_reset_o && reg_wr_i && !reg_sel_i && watchdog_enable_i
    && reg_wdata_i != 8'h55 && reg_wdata_i != 8'haa |=> mcu_reset_o && reset_cause_status_o[5])
    else $error("bad status write kept running");
  // Reset pulse is exactly sixteen cycles
  a_hold_len: assert property ($rose(mcu_reset_o) |-> mcu_reset_o[*8] ##1 mcu_reset_o[*8] ##1 !mcu_reset_o)
    else $error("reset pulse length");
  a_flags_hold: assert property (!$rose(mcu_reset_o) |-> $stable(reset_cause_status_o))
    else $error("status changed outside reset entry");
  a_rd_status: assert property (reg_rd_i && !reg_sel_i |=> reg_rdata_o == $past(reset_cause_status_o))
    else $error("status read data");
  a_force_read: assert property (reg_rd_i && reg_sel_i |=> reg_rdata_o == 8'h00)
    else $error("force register read not zero");
  a_zero_bit: assert property (reset_cause_status_o[0] == 1'b0)
    else $error("status bit 0 set");
endmodule : rcs_props

// [tb/rcs_host_model.sv]
/* CPU software and debug host on the register port.
   Callers start just after a rising edge; strobes last one cycle. */
`timescale 1ns/1ps
module rcs_host_model (
  // Clock and read data
  input  wire logic       ref_clk_i,
  input  wire logic [7:0] reg_rdata_i,
  // Register port drive
  output logic            reg_sel_o,
  output logic            reg_wr_o,
  output logic            reg_rd_o,
  output logic            reg_bdm_o,
  output logic [7:0]      reg_wdata_o
);
  // Idle port at time zero
  initial begin
    {reg_sel_o, reg_wr_o, reg_rd_o, reg_bdm_o} = 4'h0;
    reg_wdata_o = 8'h00;
  end
  // Write, then an idle cycle; data inverts, so the idle value after 0x55 is 0xaa and after 0xaa is 0x55
  task automatic wr(input logic sel, input logic bdm, input logic [7:0] v);
    {reg_sel_o, reg_bdm_o, reg_wdata_o, reg_wr_o} = {sel, bdm, v, 1'b1};
    @(posedge ref_clk_i) #1;
    {reg_bdm_o, reg_wdata_o, reg_wr_o} = {1'b0, ~v, 1'b0};
    @(posedge ref_clk_i) #1;
  endtask : wr
  // Read data is registered on the read edge
  task automatic rd(input logic sel, output logic [7:0] v);
    {reg_sel_o, reg_rd_o} = {sel, 1'b1};
    @(posedge ref_clk_i) #1;
    reg_rd_o = 1'b0;
    v = reg_rdata_i;
    @(posedge ref_clk_i) #1;
  endtask : rd
  // Service pair in the only order that clears the counter
  task automatic service();
    wr(1'b0, 1'b0, 8'h55);
    wr(1'b0, 1'b0, 8'haa);
  endtask : service
endmodule : rcs_host_model

// [tb/reset_source_status_and_debug_reset_bench.sv]
/* Self-checking bench of the reset-cause block with a host model.
   Watchdog timeout shortened to 20 cycles; 50 MHz clock. */
`timescale 1ns/1ps
module reset_source_status_and_debug_reset_bench;
  logic       ref_clk_i, resetn_i, ext_reset_n_i, undervoltage_i, ext_clk_missing_i, opcode_unimpl_i;
  logic       halt_instr_i, debug_halt_instruction_i, bad_address_i, watchdog_enable_i;
  logic       halt_mode_permit_i, background_mode_permit_i, undervoltage_reset_enable_i;
  logic       reg_sel_i, reg_wr_i, reg_rd_i, reg_bdm_i, mcu_reset_o;
  logic [7:0] reg_wdata_i, reg_rdata_o, reset_cause_status_o, d;
  int         error_cnt = 0, n_tests = 0;
  rcs_reset_status #(.WDOG_TIMEOUT_CYCLES(20)) dut (.*);
  rcs_host_model host (.ref_clk_i, .reg_rdata_i(reg_rdata_o), .reg_sel_o(reg_sel_i), .reg_wr_o(reg_wr_i),
    .reg_rd_o(reg_rd_i), .reg_bdm_o(reg_bdm_i), .reg_wdata_o(reg_wdata_i));
  // 20 ns clock
  initial begin
    ref_clk_i = 1'b0;
    forever #10 ref_clk_i = ~ref_clk_i;
  end
  // Hang guard, far above the few hundred cycles the run needs
  initial begin
    repeat (3000) @(posedge ref_clk_i);
    error_cnt++;
    end_of_test();
  end
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", n, e, g);
      error_cnt++;
    end
  endtask : chk
  task automatic idle_src();
    {ext_reset_n_i, undervoltage_i, ext_clk_missing_i, opcode_unimpl_i} = 4'h8;
    {halt_instr_i, debug_halt_instruction_i, bad_address_i} = 3'h0;
  endtask : idle_src
  // Bounded wait for the reset output to reach a level
  task automatic wait_rst(input logic v);
    for (int i = 0; i < 60 && mcu_reset_o !== v; i++) @(posedge ref_clk_i) #1;
    chk("mcu_reset_o", {7'h00, v}, {7'h00, mcu_reset_o});
  endtask : wait_rst
  task automatic t_por();
    resetn_i = 1'b0;
    repeat (8) @(posedge ref_clk_i);
    #1 resetn_i = 1'b1;
    chk("status_o", 8'h82, reset_cause_status_o);
    wait_rst(1'b1);
    wait_rst(1'b0);
  endtask : t_por
  // One source (pin plus clock loss in the default case) for one cycle, then the captured cause through a read
  task automatic t_source(input int k, input logic [7:0] e);
    case (k)
      0: undervoltage_i = 1'b1;
      1: ext_reset_n_i = 1'b0;
      2: ext_clk_missing_i = 1'b1;
      3: opcode_unimpl_i = 1'b1;
      4: halt_instr_i = 1'b1;
      5: debug_halt_instruction_i = 1'b1;
      6: bad_address_i = 1'b1;
      default: {ext_reset_n_i, ext_clk_missing_i} = 2'h1;
    endcase
    @(posedge ref_clk_i) #1;
    idle_src();
    wait_rst(1'b1);
    wait_rst(1'b0);
    host.rd(1'b0, d);
    chk("status", e, d);
    chk("status_o", e, reset_cause_status_o);
  endtask : t_source
  // Permitted halt and debug halt, and undervoltage with its reset off, must not reset
  task automatic t_legal();
    {halt_mode_permit_i, background_mode_permit_i, halt_instr_i, debug_halt_instruction_i} = 4'hf;
    {undervoltage_reset_enable_i, undervoltage_i} = 2'h1;
    @(posedge ref_clk_i) #1;
    idle_src();
    repeat (3) @(posedge ref_clk_i) #1;
    chk("mcu_reset_o", 8'h00, {7'h00, mcu_reset_o});
    chk("status_o", 8'h10, reset_cause_status_o);
    {halt_mode_permit_i, background_mode_permit_i, undervoltage_reset_enable_i} = 3'h1;
  endtask : t_legal
  task automatic t_wdog();
    watchdog_enable_i = 1'b1;
    repeat (8) begin
      host.service();
      repeat (8) @(posedge ref_clk_i) #1;
    end
    chk("mcu_reset_o", 8'h00, {7'h00, mcu_reset_o});
    chk("status_o", 8'h08, reset_cause_status_o);
    host.wr(1'b0, 1'b0, 8'h33);
    chk("mcu_reset_o", 8'h01, {7'h00, mcu_reset_o});
    watchdog_enable_i = 1'b0;
    wait_rst(1'b0);
    chk("status_o", 8'h20, reset_cause_status_o);
    t_source(3, 8'h10);
    // A lone second code must not clear: the timeout still pulses 20 edges after enable and the reset starts on edge 21
    watchdog_enable_i = 1'b1;
    repeat (8) @(posedge ref_clk_i) #1;
    host.wr(1'b0, 1'b0, 8'haa);
    repeat (12) @(posedge ref_clk_i) #1;
    chk("mcu_reset_o", 8'h01, {7'h00, mcu_reset_o});
    watchdog_enable_i = 1'b0;
    wait_rst(1'b0);
    chk("status_o", 8'h20, reset_cause_status_o);
    host.wr(1'b0, 1'b0, 8'h33);
    repeat (40) @(posedge ref_clk_i) #1;
    chk("mcu_reset_o", 8'h00, {7'h00, mcu_reset_o});
  endtask : t_wdog
  task automatic t_dbg();
    host.wr(1'b1, 1'b0, 8'h01);
    chk("mcu_reset_o", 8'h00, {7'h00, mcu_reset_o});
    host.rd(1'b1, d);
    chk("force_rd", 8'h00, d);
    host.wr(1'b1, 1'b1, 8'h01);
    wait_rst(1'b1);
    wait_rst(1'b0);
    chk("status_o", 8'h00, reset_cause_status_o);
  endtask : t_dbg
  task automatic end_of_test();
    if (error_cnt == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test
  // Main sequence
  initial begin
    idle_src();
    {watchdog_enable_i, halt_mode_permit_i, background_mode_permit_i, undervoltage_reset_enable_i} = 4'h1;
    t_por();
    t_source(0, 8'h82);
    t_source(1, 8'h40);
    t_source(2, 8'h04);
    t_source(4, 8'h10);
    t_source(5, 8'h10);
    t_legal();
    t_source(6, 8'h08);
    t_wdog();
    t_dbg();
    t_source(7, 8'h44);
    t_source(0, 8'h02);
    t_por();
    end_of_test();
  end
endmodule : reset_source_status_and_debug_reset_bench
bind rcs_reset_status rcs_props u_props (.*);
